/* common/sdram_timing_pkg.sv */
// Shared register map, field layout, command codes and states of the SDRAM timing sequencer
package sdram_timing_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [3:0] ADDR_CTRL = 4'h0;     // Enable, self-refresh, access mode
  localparam logic [3:0] ADDR_REF_LO = 4'h4;   // Refresh period, low byte
  localparam logic [3:0] ADDR_REF_HI = 4'h5;   // Refresh period, bits 9:8
  localparam logic [3:0] ADDR_INIT_LO = 4'h6;  // Startup delay, low byte
  localparam logic [3:0] ADDR_INIT_HI = 4'h7;  // Startup delay, bits 13:8
  localparam logic [3:0] ADDR_TIM_B = 4'h8;    // sdram_timing_control_b
  localparam logic [3:0] ADDR_TIM_C = 4'h9;    // sdram_timing_control_c
  localparam logic [3:0] ADDR_STATUS = 4'hA;   // Read-only state

  // ----------------------------------------
  // Field positions and reset values
  // ----------------------------------------
  localparam int CTRL_EN_BIT = 0;      // Controller enable
  localparam int CTRL_SREF_BIT = 1;    // self_refresh_enable
  localparam int CTRL_MODE_LSB = 2;    // sdram_access_mode, 2 bits
  localparam int TB_MRD_LSB = 6;       // mode_to_active_delay, 2 bits
  localparam int TB_RC_LSB = 3;        // refresh_to_active_delay, 3 bits
  localparam int TB_RP_LSB = 0;        // active_to_precharge_delay, 3 bits
  localparam int TC_WR_LSB = 6;        // write_recovery_delay, 2 bits
  localparam int TC_ESR_LSB = 3;       // self_refresh_exit_delay, 3 bits
  localparam int TC_RCD_LSB = 0;       // active_to_rw_delay, 3 bits
  localparam logic [7:0] REG_RESET = 8'h00;       // All registers clear
  localparam logic [1:0] MODE_LOAD = 2'h1;        // Access turns into a mode load
  localparam logic [2:0] PEND_MAX = 3'h4;         // Refreshes remembered at most

  // ----------------------------------------
  // SDRAM commands: {cs_n, ras_n, cas_n, we_n}
  // ----------------------------------------
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_RD = 4'h5;
  localparam logic [3:0] CMD_WR = 4'h4;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_LMR = 4'h0;

  typedef struct packed {
    logic cke;         // Clock enable pin
    logic [3:0] code;  // Command pins, active low each
  } sdram_cmd_t;

  typedef enum logic [7:0] {
    ST_OFF = 8'h01,
    ST_STARTUP = 8'h02,
    ST_INIT_REF = 8'h04,
    ST_INIT_MODE = 8'h08,
    ST_READY = 8'h10,
    ST_RW = 8'h20,
    ST_CLOSE = 8'h40,
    ST_SREF = 8'h80
  } state_t;

endpackage : sdram_timing_pkg

/* rtl/sdram_delay_counter.sv */
// Down counter that spaces two SDRAM commands by a loaded number of cycles
`timescale 1ns/1ps
module sdram_delay_counter
  import sdram_timing_pkg::*;
(
  input wire logic clk,               // Doubled peripheral clock
  input wire logic rst_n,             // Async reset, active low
  input wire logic load,              // Start a new gap
  input wire logic [13:0] loadValue,  // Idle cycles wanted
  output logic zero                   // Gap over, next command may go
);

  logic [13:0] count;       // Remaining idle cycles
  logic [13:0] next_count;  // Next remaining count

  // ----------------------------------------
  // Next count
  // ----------------------------------------
  always_comb begin
    next_count = count;
    if (load) begin
      next_count = loadValue;
    end else if (count != 14'h0000) begin
      next_count = count - 14'h0001;
    end
  end

  // ----------------------------------------
  // Count register
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= 14'h0000;
    end else begin
      count <= next_count;
    end
  end

  // A value of zero frees the next command on the very next cycle
  assign zero = (count == 14'h0000);

endmodule : sdram_delay_counter

/* rtl/sdram_refresh_tracker.sv */
// Refresh period timer with a small store of refreshes owed
`timescale 1ns/1ps
module sdram_refresh_tracker
  import sdram_timing_pkg::*;
(
  input wire logic clk,           // Doubled peripheral clock
  input wire logic rst_n,         // Async reset, active low
  input wire logic [9:0] period,  // Refresh period, zero stops it
  input wire logic flush,         // Drop the store, memory refreshes itself
  input wire logic take,          // One refresh issued
  output logic [2:0] pending      // Refreshes owed
);

  logic [9:0] timer;        // Cycles into the period
  logic [9:0] next_timer;   // Next timer value
  logic [2:0] next_pending; // Next owed count
  logic tick;               // Period elapsed

  // ----------------------------------------
  // Timer and store, next values
  // ----------------------------------------
  always_comb begin
    tick = (period != 10'h000) && (timer >= period - 10'h001);
    next_timer = tick ? 10'h000 : timer + 10'h001;
    if (period == 10'h000) begin
      next_timer = 10'h000;
    end
    next_pending = pending;
    // A tick in the same cycle as a take leaves the count as it was
    if (flush) begin
      next_pending = 3'h0;
    end else if (tick && !take && pending < PEND_MAX) begin
      next_pending = pending + 3'h1;
    end else if (take && !tick && pending != 3'h0) begin
      next_pending = pending - 3'h1;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timer <= 10'h000;
      pending <= 3'h0;
    end else begin
      timer <= next_timer;
      pending <= next_pending;
    end
  end

  chk_pend_limit: assert property (@(posedge clk) disable iff (!rst_n)
    pending <= PEND_MAX) else $error("refresh store above four");

endmodule : sdram_refresh_tracker

/* rtl/sdram_timing_sequencer.sv */
// SDRAM startup, initialisation and command spacing sequencer with its registers
//
// Operation
// - Wait startup delay after enable before init
// - Init order: precharge all, refresh, mode load
// - Startup delay is 14 bits of cycles
// - Mode load to active spaced by field
// - Refresh to active spaced by field
// - Active to precharge spaced by field
// - Write recovery before precharge after write
// - Self-refresh exit to active spaced by field
// - Active to read or write spaced
// - Periodic refresh, up to four remembered
// - Self-refresh bit enters and leaves self-refresh
// - Load mode turns access into mode load
//
// Strobed register access is this design's own decision.
`timescale 1ns/1ps
module sdram_timing_sequencer
  import sdram_timing_pkg::*;
(
  input wire logic clk,              // Doubled peripheral clock, 125 MHz
  input wire logic rst_n,            // Async reset, active low
  input wire logic [3:0] regAddr,    // Register offset
  input wire logic [7:0] regWdata,   // Register write data
  input wire logic regWr,            // Write strobe
  input wire logic regRd,            // Read strobe
  output logic [7:0] regRdata,       // Read data, cycle after strobe
  input wire logic accReq,           // Access request, held until ack
  input wire logic accWrite,         // Access is a write
  output logic accAck,               // Access finished, one cycle
  output sdram_cmd_t sdramOut        // CKE and command pins
);

  // ----------------------------------------
  // Register state
  // ----------------------------------------
  logic [3:0] ctrl;          // Enable, self-refresh, mode
  logic [9:0] refPeriod;     // Refresh period
  logic [13:0] initDelay;    // startup_delay_count
  logic [7:0] timB;          // sdram_timing_control_b
  logic [7:0] timC;          // sdram_timing_control_c
  logic [3:0] next_ctrl;
  logic [9:0] next_refPeriod;
  logic [13:0] next_initDelay;
  logic [7:0] next_timB;
  logic [7:0] next_timC;
  logic [7:0] next_regRdata;

  // ----------------------------------------
  // Sequencer state
  // ----------------------------------------
  state_t state;             // Current step
  state_t next_state;
  sdram_cmd_t next_sdramOut;
  logic next_accAck;
  logic initDone;            // Init sequence complete
  logic next_initDone;
  logic mainLoad;            // Start a command gap
  logic [13:0] mainValue;    // Gap length
  logic mainZero;            // Gap over
  logic rasLoad;             // Start active-to-precharge gap
  logic rasZero;             // Row may close
  logic refTake;             // Refresh issued from the store
  logic [2:0] refPending;    // Refreshes owed

  // Field views
  logic enable;
  logic srefReq;
  logic [1:0] accessMode;
  logic [1:0] mrdField;
  logic [2:0] rcField;
  logic [2:0] rpField;
  logic [1:0] wrField;
  logic [2:0] esrField;
  logic [2:0] rcdField;

  always_comb begin
    enable = ctrl[CTRL_EN_BIT];
    srefReq = ctrl[CTRL_SREF_BIT];
    accessMode = ctrl[CTRL_MODE_LSB +: 2];
    mrdField = timB[TB_MRD_LSB +: 2];
    rcField = timB[TB_RC_LSB +: 3];
    rpField = timB[TB_RP_LSB +: 3];
    wrField = timC[TC_WR_LSB +: 2];
    esrField = timC[TC_ESR_LSB +: 3];
    rcdField = timC[TC_RCD_LSB +: 3];
  end

  // ----------------------------------------
  // Register writes and read mux
  // ----------------------------------------
  always_comb begin
    next_ctrl = ctrl;
    next_refPeriod = refPeriod;
    next_initDelay = initDelay;
    next_timB = timB;
    next_timC = timC;
    next_regRdata = 8'h00;
    if (regWr) begin
      case (regAddr)
        ADDR_CTRL: next_ctrl = regWdata[3:0];
        ADDR_REF_LO: next_refPeriod[7:0] = regWdata;
        ADDR_REF_HI: next_refPeriod[9:8] = regWdata[1:0];
        ADDR_INIT_LO: next_initDelay[7:0] = regWdata;
        ADDR_INIT_HI: next_initDelay[13:8] = regWdata[5:0];
        ADDR_TIM_B: next_timB = regWdata;
        ADDR_TIM_C: next_timC = regWdata;
        default: next_ctrl = ctrl; // Unmapped writes are dropped
      endcase
    end
    if (regRd) begin
      case (regAddr)
        ADDR_CTRL: next_regRdata = {4'h0, ctrl};
        ADDR_REF_LO: next_regRdata = refPeriod[7:0];
        ADDR_REF_HI: next_regRdata = {6'h00, refPeriod[9:8]};
        ADDR_INIT_LO: next_regRdata = initDelay[7:0];
        ADDR_INIT_HI: next_regRdata = {2'h0, initDelay[13:8]};
        ADDR_TIM_B: next_regRdata = timB;
        ADDR_TIM_C: next_regRdata = timC;
        ADDR_STATUS: next_regRdata = {3'h0, refPending, state == ST_SREF, initDone};
        default: next_regRdata = 8'h00; // Unmapped reads give zero
      endcase
    end
  end

  // ----------------------------------------
  // Register file flops
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= REG_RESET[3:0];
      refPeriod <= {2'h0, REG_RESET};
      initDelay <= {6'h00, REG_RESET};
      timB <= REG_RESET;
      timC <= REG_RESET;
      regRdata <= REG_RESET;
    end else begin
      ctrl <= next_ctrl;
      refPeriod <= next_refPeriod;
      initDelay <= next_initDelay;
      timB <= next_timB;
      timC <= next_timC;
      regRdata <= next_regRdata;
    end
  end

  // ----------------------------------------
  // Command sequencer, next values
  // ----------------------------------------
  // Every command except the self-refresh entry loads the gap counter; every next command except that entry waits for it to run out.
  // The row-open gap runs on a second counter so a short column gap cannot cut it.
  always_comb begin
    next_state = state;
    next_sdramOut = '{cke: 1'b1, code: CMD_NOP};
    next_accAck = 1'b0;
    next_initDone = initDone;
    mainLoad = 1'b0;
    mainValue = 14'h0000;
    rasLoad = 1'b0;
    refTake = 1'b0;
    case (state)
      ST_OFF: begin
        if (enable) begin
          mainLoad = 1'b1;
          mainValue = initDelay;
          next_state = ST_STARTUP;
        end
      end
      ST_STARTUP: begin
        if (mainZero) begin
          next_sdramOut.code = CMD_PRE;
          mainLoad = 1'b1;
          next_state = ST_INIT_REF;
        end
      end
      ST_INIT_REF: begin
        if (mainZero) begin
          next_sdramOut.code = CMD_REF;
          mainLoad = 1'b1;
          mainValue = {11'h000, rcField};
          next_state = ST_INIT_MODE;
        end
      end
      ST_INIT_MODE: begin
        if (mainZero) begin
          next_sdramOut.code = CMD_LMR;
          mainLoad = 1'b1;
          mainValue = {12'h000, mrdField};
          next_initDone = 1'b1;
          next_state = ST_READY;
        end
      end
      ST_READY: begin
        if (srefReq) begin
          next_sdramOut = '{cke: 1'b0, code: CMD_REF};
          next_state = ST_SREF;
        end else if (mainZero && refPending != 3'h0) begin
          next_sdramOut.code = CMD_REF;
          refTake = 1'b1;
          mainLoad = 1'b1;
          mainValue = {11'h000, rcField};
        end else if (mainZero && accReq && !accAck && accessMode == MODE_LOAD) begin
          next_sdramOut.code = CMD_LMR;
          next_accAck = 1'b1;
          mainLoad = 1'b1;
          mainValue = {12'h000, mrdField};
        end else if (mainZero && accReq && !accAck) begin // Request seen beside an ack is the finished one
          next_sdramOut.code = CMD_ACT;
          mainLoad = 1'b1;
          mainValue = {11'h000, rcdField};
          rasLoad = 1'b1;
          next_state = ST_RW;
        end
      end
      ST_RW: begin
        if (mainZero) begin
          next_sdramOut.code = accWrite ? CMD_WR : CMD_RD;
          mainLoad = 1'b1;
          mainValue = accWrite ? {12'h000, wrField} : 14'h0000;
          next_state = ST_CLOSE;
        end
      end
      ST_CLOSE: begin
        if (mainZero && rasZero) begin
          next_sdramOut.code = CMD_PRE;
          next_accAck = 1'b1;
          mainLoad = 1'b1;
          next_state = ST_READY;
        end
      end
      ST_SREF: begin
        next_sdramOut.cke = 1'b0;
        if (!srefReq) begin
          next_sdramOut.cke = 1'b1;
          mainLoad = 1'b1;
          mainValue = {11'h000, esrField};
          next_state = ST_READY;
        end
      end
      default: next_state = ST_OFF;
    endcase
    // Dropping the enable abandons any step and forgets the init
    if (!enable) begin
      next_state = ST_OFF;
      next_initDone = 1'b0;
      next_sdramOut = '{cke: 1'b1, code: CMD_NOP};
      next_accAck = 1'b0;
    end
  end

  // ----------------------------------------
  // Sequencer flops
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_OFF;
      sdramOut <= '{cke: 1'b1, code: CMD_NOP};
      accAck <= 1'b0;
      initDone <= 1'b0;
    end else begin
      state <= next_state;
      sdramOut <= next_sdramOut;
      accAck <= next_accAck;
      initDone <= next_initDone;
    end
  end

  // ----------------------------------------
  // Gap counters and refresh store
  // ----------------------------------------
  sdram_delay_counter mainGap (
    .clk(clk),
    .rst_n(rst_n),
    .load(mainLoad),
    .loadValue(mainValue),
    .zero(mainZero)
  );

  sdram_delay_counter rowGap (
    .clk(clk),
    .rst_n(rst_n),
    .load(rasLoad),
    .loadValue({11'h000, rpField}),
    .zero(rasZero)
  );

  sdram_refresh_tracker refresher (
    .clk(clk),
    .rst_n(rst_n),
    .period(refPeriod),
    .flush(state == ST_SREF || state == ST_OFF),
    .take(refTake),
    .pending(refPending)
  );

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  chk_startup_hold: assert property (@(posedge clk) disable iff (!rst_n)
    (state == ST_STARTUP && !mainZero) |=> sdramOut.code == CMD_NOP) else $error("command during startup delay");

  chk_init_order: assert property (@(posedge clk) disable iff (!rst_n)
    (state == ST_STARTUP && mainZero && enable && rcField == 3'h7)
      |=> sdramOut.code == CMD_PRE ##1 sdramOut.code == CMD_REF ##8 sdramOut.code == CMD_LMR)
    else $error("init sequence out of order");

  chk_mrd_gap: assert property (@(posedge clk) disable iff (!rst_n)
    (sdramOut.code == CMD_LMR && mrdField == 2'h3) |=> (sdramOut.code != CMD_ACT)[*3]) else $error("mode gap short");

  chk_rc_gap: assert property (@(posedge clk) disable iff (!rst_n)
    (sdramOut.code == CMD_REF && sdramOut.cke && rcField == 3'h7) |=> (sdramOut.code != CMD_ACT)[*7])
    else $error("refresh gap short");

  chk_rp_gap: assert property (@(posedge clk) disable iff (!rst_n)
    (sdramOut.code == CMD_ACT && rpField == 3'h7) |=> (sdramOut.code != CMD_PRE)[*7]) else $error("row closed early");

  chk_wr_gap: assert property (@(posedge clk) disable iff (!rst_n)
    (sdramOut.code == CMD_WR && wrField == 2'h3) |=> (sdramOut.code != CMD_PRE)[*3]) else $error("write recovery short");

  chk_esr_gap: assert property (@(posedge clk) disable iff (!rst_n)
    ($rose(sdramOut.cke) && esrField == 3'h7) |-> (sdramOut.code != CMD_ACT)[*8]) else $error("self-refresh exit short");

  chk_rcd_gap: assert property (@(posedge clk) disable iff (!rst_n)
    (sdramOut.code == CMD_ACT && rcdField == 3'h7)
      |=> (sdramOut.code != CMD_RD && sdramOut.code != CMD_WR)[*7]) else $error("column gap short");

  chk_zero_gap: assert property (@(posedge clk) disable iff (!rst_n)
    (sdramOut.code == CMD_ACT && rcdField == 3'h0 && enable)
      |=> sdramOut.code == CMD_RD || sdramOut.code == CMD_WR) else $error("zero gap added idle cycle");

  chk_sref_entry: assert property (@(posedge clk) disable iff (!rst_n)
    (state == ST_READY && srefReq && enable) |=> !sdramOut.cke && sdramOut.code == CMD_REF)
    else $error("self-refresh not entered");

  chk_load_mode: assert property (@(posedge clk) disable iff (!rst_n)
    (state == ST_READY && mainZero && accReq && !accAck && accessMode == MODE_LOAD && enable && !srefReq
      && refPending == 3'h0)
      |=> sdramOut.code == CMD_LMR && accAck) else $error("load mode access not a mode load");

endmodule : sdram_timing_sequencer

/* dv/sdram_chip_model.sv */
// Stand-in SDRAM chip that stamps ACT, RD, WR, REF, LMR and CKE rises and reports the idle gaps
`timescale 1ns/1ps
module sdram_chip_model
  import sdram_timing_pkg::*;
(
  input wire logic clk,           // Memory clock
  input wire logic rst_n,         // Async reset, active low
  input wire sdram_cmd_t sdramIn, // CKE and command pins
  output logic cmdSeen,           // A command arrived last cycle
  output logic [3:0] cmdCode,     // Its code
  output int gapAct,              // Idle cycles since last ACT
  output int gapRw,               // Idle cycles since last RD or WR
  output int gapRef,              // Idle cycles since last REF
  output int gapLmr,              // Idle cycles since last LMR
  output int gapWake              // Idle cycles since CKE rose
);
  int cyc;                          // Free running cycle count
  int tAct, tRw, tRef, tLmr, tWake; // Stamps of the latest events
  logic ckeOld;                     // CKE one cycle ago

  // A real chip only acts on commands with CKE high; self-refresh entry is not counted
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cyc <= 0;
      {tAct, tRw, tRef, tLmr, tWake} <= {5{-32'sd99}}; // Far in the past
      {gapAct, gapRw, gapRef, gapLmr, gapWake} <= {5{32'sd0}};
      cmdSeen <= 1'b0;
      cmdCode <= CMD_NOP;
      ckeOld <= 1'b1;
    end else begin
      cyc <= cyc + 1;
      ckeOld <= sdramIn.cke;
      cmdSeen <= sdramIn.cke && (sdramIn.code != CMD_NOP);
      cmdCode <= sdramIn.code;
      gapAct <= cyc - tAct - 1;
      gapRw <= cyc - tRw - 1;
      gapRef <= cyc - tRef - 1;
      gapLmr <= cyc - tLmr - 1;
      gapWake <= cyc - tWake - 1;
      if (sdramIn.cke && !ckeOld) tWake <= cyc;
      if (sdramIn.cke && sdramIn.code == CMD_ACT) tAct <= cyc;
      if (sdramIn.cke && (sdramIn.code == CMD_RD || sdramIn.code == CMD_WR)) tRw <= cyc;
      if (sdramIn.cke && sdramIn.code == CMD_REF) tRef <= cyc;
      if (sdramIn.cke && sdramIn.code == CMD_LMR) tLmr <= cyc;
    end
  end
endmodule : sdram_chip_model

/* dv/sdram_timing_sequencer_tb.sv */
// Self-checking bench for the SDRAM timing sequencer
`timescale 1ns/1ps
module sdram_timing_sequencer_tb
  import sdram_timing_pkg::*;
;
  logic clk = 1'b0;             // 125 MHz
  logic rst_n = 1'b0;           // Held for 10 cycles
  logic [3:0] regAddr = 4'h0;   // Register bus
  logic [7:0] regWdata = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [7:0] regRdata;
  logic accReq = 1'b0;          // Access port
  logic accWrite = 1'b0;
  logic accAck;
  sdram_cmd_t sdramOut;
  logic cmdSeen;                // Partner reports
  logic [3:0] cmdCode;
  int gapAct, gapRw, gapRef, gapLmr, gapWake;
  int errors = 0;
  int samples_checked = 0;
  int cyc = 0;                  // Timeout counter
  int enCyc, startupWait, refCount; // Startup stamp and refresh tally
  int rc, mrd, rp, wr, esr, rcd; // Shadow of the timing fields
  logic lastWrite;              // Kind of the access in flight
  logic [3:0] initQ[$];         // First three commands after enable
  logic [7:0] rd;

  always #4 clk = ~clk;

  sdram_timing_sequencer dut (.clk(clk), .rst_n(rst_n), .regAddr(regAddr), .regWdata(regWdata),
    .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .accReq(accReq), .accWrite(accWrite),
    .accAck(accAck), .sdramOut(sdramOut));
  sdram_chip_model mem (.clk(clk), .rst_n(rst_n), .sdramIn(sdramOut), .cmdSeen(cmdSeen),
    .cmdCode(cmdCode), .gapAct(gapAct), .gapRw(gapRw), .gapRef(gapRef), .gapLmr(gapLmr),
    .gapWake(gapWake));

  // ----------------------------------------
  // Compare tasks and bus tasks
  // ----------------------------------------
  task automatic checkVal(input logic [7:0] got, input logic [7:0] exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : checkVal

  task automatic checkGap(input int got, input int lo, input int hi, input string what);
    samples_checked++;
    if (got < lo || got > hi) begin
      errors++;
      $display("[ERR] %0t %s gap %0d not in %0d..%0d", $time, what, got, lo, hi);
    end
  endtask : checkGap

  task automatic checkCmd(input sdram_cmd_t got, input sdram_cmd_t exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : checkCmd

  task automatic regWrite(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWdata <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask : regWrite

  // Read data stand only in the cycle after the strobe
  task automatic regRead(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
    @(posedge clk);
    d = regRdata;
  endtask : regRead

  task automatic setTiming(input logic [7:0] b, input logic [7:0] c);
    regWrite(ADDR_TIM_B, b);
    regWrite(ADDR_TIM_C, c);
    {mrd, rc, rp} = {30'd0, b[7:6], 29'd0, b[5:3], 29'd0, b[2:0]};
    {wr, esr, rcd} = {30'd0, c[7:6], 29'd0, c[5:3], 29'd0, c[2:0]};
    regRead(ADDR_TIM_B, rd);
    checkVal(rd, b, "timing b");
    regRead(ADDR_TIM_C, rd);
    checkVal(rd, c, "timing c");
  endtask : setTiming

  // Request held until the one-cycle ack; the closing command comes with it
  task automatic access(input logic w, input logic [3:0] endCode, input int limit);
    int n;
    n = 0;
    lastWrite = w;
    @(posedge clk);
    accReq <= 1'b1;
    accWrite <= w;
    do begin
      @(posedge clk);
      n++;
    end while (accAck !== 1'b1 && n < limit);
    checkCmd(sdramOut, {1'b1, endCode}, "command with ack");
    accReq <= 1'b0;
  endtask : access

  function automatic int expClose();
    int e;
    e = rp - rcd - 1; // Row gap left after the column command
    if (lastWrite && wr > e) e = wr;
    return (e < 0) ? 0 : e;
  endfunction : expClose

  task automatic print_verdict();
    $display("errors %0d samples_checked %0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : print_verdict

  // ----------------------------------------
  // Command spacing monitor and timeout
  // ----------------------------------------
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cmdSeen === 1'b1) begin
      if (initQ.size() < 3) begin
        initQ.push_back(cmdCode);
        if (initQ.size() == 1) checkGap(cyc - enCyc, startupWait, 99999, "startup");
        if (cmdCode === CMD_LMR) checkGap(gapRef, rc, 99999, "init ref to mode");
      end else begin
        case (cmdCode)
          CMD_ACT: begin
            checkGap(gapRef, rc, 99999, "ref to act");
            checkGap(gapLmr, mrd, 99999, "mode to act");
            checkGap(gapWake, esr, 99999, "wake to act");
          end
          CMD_RD, CMD_WR: checkGap(gapAct, rcd, rcd, "act to rw");
          CMD_PRE: checkGap(gapRw, expClose(), expClose(), "close");
          CMD_REF: refCount++;
          default: ;
        endcase
      end
    end
    if (cyc > 60000) begin
      errors++;
      $display("[ERR] %0t timeout", $time);
      print_verdict();
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    void'($urandom(76550));
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    regRead(ADDR_TIM_B, rd);
    checkVal(rd, REG_RESET, "reset b");
    regRead(ADDR_TIM_C, rd);
    checkVal(rd, REG_RESET, "reset c");
    regRead(4'hF, rd);
    checkVal(rd, 8'h00, "unmapped");
    regWrite(ADDR_REF_HI, 8'hFF);
    regRead(ADDR_REF_HI, rd);
    checkVal(rd, 8'h03, "period high");
    regWrite(ADDR_REF_HI, 8'h00);
    // Longest startup delay and slowest gaps, request waiting through init
    regWrite(ADDR_INIT_LO, 8'hFF);
    regWrite(ADDR_INIT_HI, 8'hFF);
    regRead(ADDR_INIT_HI, rd);
    checkVal(rd, 8'h3F, "delay high");
    startupWait = 16383;
    setTiming(8'hFF, 8'hFF);
    regWrite(ADDR_CTRL, 8'h01);
    enCyc = cyc;
    access(1'b0, CMD_PRE, 20000);
    checkGap(initQ.size(), 3, 3, "init count");
    for (int i = 0; i < 3 && i < initQ.size(); i++) begin
      checkCmd({1'b1, initQ[i]}, {1'b1, (i == 0) ? CMD_PRE : (i == 1) ? CMD_REF : CMD_LMR}, "init");
    end
    // Zero gaps, back to back, then random gaps with corner values first
    setTiming(8'h00, 8'h00);
    access(1'b0, CMD_PRE, 50);
    access(1'b1, CMD_PRE, 50);
    setTiming(8'h07, 8'hC7);
    access(1'b1, CMD_PRE, 50);
    repeat (12) begin
      setTiming(8'($urandom), 8'($urandom));
      access(1'($urandom), CMD_PRE, 80);
    end
    // Load mode turns the access into a mode load
    regWrite(ADDR_CTRL, 8'h05);
    access(1'b0, CMD_LMR, 50);
    regWrite(ADDR_CTRL, 8'h01);
    // Self-refresh entry and exit with the longest wake gap
    setTiming(8'h00, 8'h38);
    regWrite(ADDR_CTRL, 8'h03);
    for (int i = 0; i < 4 && sdramOut.cke !== 1'b0; i++) @(posedge clk);
    checkCmd(sdramOut, {1'b0, CMD_REF}, "self-refresh entry");
    regRead(ADDR_STATUS, rd);
    checkVal(rd & 8'h02, 8'h02, "in self-refresh");
    regWrite(ADDR_CTRL, 8'h01);
    access(1'b1, CMD_PRE, 50);
    // Period of one with slow refreshes saturates the store
    setTiming(8'h38, 8'h00);
    regWrite(ADDR_REF_LO, 8'h01);
    repeat (60) @(posedge clk);
    regRead(ADDR_STATUS, rd);
    checkVal(rd & 8'h1C, 8'h10, "refreshes owed");
    setTiming(8'h00, 8'h00);
    regWrite(ADDR_REF_LO, 8'd25);
    repeat (60) @(posedge clk);
    refCount = 0;
    repeat (250) @(posedge clk);
    checkGap(refCount, 9, 11, "refresh rate");
    regWrite(ADDR_REF_LO, 8'h00);
    print_verdict();
  end
endmodule : sdram_timing_sequencer_tb
